// File: common/spi_port_pkg.sv
// Purpose: Shared constants and types for the synchronous serial port.
// Assumes: 100 MHz clk; registers are reached as aligned 32-bit words.
// Notes: Registers are 8 bits wide in the low byte lane; upper bits read 0.
package spi_port_pkg;

  // Register byte offsets
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_BUFFER = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_PINS = 4'hc;

  // Status register bit positions
  localparam int STAT_SAMPLE = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_STOP = 4;
  localparam int STAT_FULL = 0;

  // Control register bit positions
  localparam int CTRL_COLLIDE = 7;
  localparam int CTRL_OV = 6;
  localparam int CTRL_EN = 5;
  localparam int CTRL_POLARITY = 4;

  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;

  // Mode field encodings
  typedef enum logic [3:0] {
    MODE_MASTER_DIV4 = 4'h0,
    MODE_MASTER_DIV16 = 4'h1,
    MODE_MASTER_DIV64 = 4'h2,
    MODE_MASTER_TIMER = 4'h3,
    MODE_SLAVE_SS = 4'h4,
    MODE_SLAVE_FREE = 4'h5
  } port_mode_t;

  // Half serial clock periods in system clocks (full period is twice this)
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;

  // Byte framing: 16 clock halves plus one closing tick
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [4:0] HALF_LAST = 5'h10;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Master transfer state
  typedef enum logic {
    XF_IDLE = 1'b0,
    XF_MASTER = 1'b1
  } xfer_t;

  // Half period length for a master mode code
  function automatic logic [5:0] half_len(input logic [3:0] mode);
    case (mode)
      MODE_MASTER_DIV16: half_len = HALF_DIV16;
      MODE_MASTER_DIV64: half_len = HALF_DIV64;
      default: half_len = HALF_DIV4;
    endcase
  endfunction : half_len

endpackage : spi_port_pkg

// File: hw/sck_rate_gen.sv
// Purpose: Half-period tick generator for the master serial clock.
// Assumes: timer_two_output is a one-cycle pulse from logic on clk.
// Notes: Timer mode toggles the clock once per timer pulse (timer/2 rate).
module sck_rate_gen
  import spi_port_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [3:0] mode,
  input wire logic timer_two_output,
  output logic tick
);

  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } gen_state_t;

  gen_state_t st_reg;
  gen_state_t st_next;

  // Count system clocks, or pass timer pulses, while a byte is running
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.cnt = '0;
    end else if (mode == MODE_MASTER_TIMER) begin
      st_next.tick = timer_two_output;
    end else if (st_reg.cnt == half_len(mode) - 6'h01) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule : sck_rate_gen

// File: hw/sync_serial_unit.sv
// Purpose: SPI-mode synchronous serial port with an AXI4-Lite register slave.
// Assumes: Pins are sampled through two flops; clk keeps running in sleep.
// Notes: Reserved mode codes leave the port enabled but with no shift engine.
//
// Overview of operation
// (R1) Eighth bit in: buffer loaded, full and flag set
// (R2) Buffer write loads buffer and shift register
// (R3) Shift most significant bit first
// (R4) Master sample point: middle or end
// (R5) Software keeps sample point clear as slave
// (R6) Clock edge bit picks output change edge
// (R7) Clock polarity sets idle clock level
// (R8) Buffer full set on receive, read clears
// (R9) Write while busy dropped, sets collision
// (R10) Slave byte onto full buffer sets overflow
// (R11) Master mode never sets overflow
// (R12) Enable hands pins to the port
// (R13) Stop bit cleared while disabled
// (R14) Mode field picks master rate or slave
// (R15) Reconfigure by disable, rewrite, enable
// (R16) Software sets pin directions
// (R17) Master starts clocking on buffer write
// (R18) Data out disabled: master still receives
// (R19) Clock edge set: data valid before clock
// (R20) Slave shifts on external clock, flags byte
// (R21) Slave clock idles correctly before enable
// (R22) Slave receives in sleep, byte wakes
// (R23) Slave select high stops output, clears count
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
module sync_serial_unit
  import spi_port_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic slave_select_n_in,
  input wire logic sdo_direction_input,
  input wire logic timer_two_output,
  output logic port_pins_active,
  output logic port_interrupt_flag,
  output logic wake_request
);

  typedef struct packed {
    // Bus slave
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    // Configuration and status
    logic sample_point;
    logic clock_edge;
    logic stop_bit;
    logic buffer_full;
    logic write_collision;
    logic receive_overflow;
    logic port_enable;
    logic clock_polarity;
    logic [3:0] port_mode_field;
    // Shift engine
    logic [7:0] transfer_buffer;
    logic [7:0] shift_register;
    logic sdo_bit;
    logic [2:0] bit_cnt;
    xfer_t xfer;
    logic [4:0] half_cnt;
    logic sck_level;
    // Pin synchronisers
    logic sck_meta;
    logic sck_sync;
    logic sck_prev;
    logic sdi_meta;
    logic sdi_sync;
    logic ss_meta;
    logic ss_sync;
    // Pin drivers and pulses
    logic sck_oe;
    logic sdo_oe;
    logic pins_active;
    logic flag;
    logic wake;
  } port_state_t;

  port_state_t st_reg;
  port_state_t st_next;
  logic tick;

  // Serial clock pacing for master transfers
  sck_rate_gen u_rate (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(st_reg.xfer == XF_MASTER),
    .mode(st_reg.port_mode_field),
    .timer_two_output(timer_two_output),
    .tick(tick)
  );

  // Decode, bus access and shift engine; software writes are applied
  // before hardware sets so that a set in the same cycle wins.
  always_comb begin
    logic is_master;
    logic is_slave;
    logic ss_high;
    logic do_wr;
    logic rd_take;
    logic buf_rd;
    logic busy;
    logic lead;
    logic trail;
    logic endt;
    logic m_mid;
    logic m_out;
    logic m_end;
    logic m_samp;
    logic s_edge;
    logic s_lead;
    logic s_trail;
    logic s_act;
    logic samp_ev;
    logic out_ev;
    logic [7:0] new_byte;
    is_master = 1'b0;
    is_slave = 1'b0;
    ss_high = 1'b0;
    do_wr = 1'b0;
    rd_take = 1'b0;
    buf_rd = 1'b0;
    busy = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    endt = 1'b0;
    m_mid = 1'b0;
    m_out = 1'b0;
    m_end = 1'b0;
    m_samp = 1'b0;
    s_edge = 1'b0;
    s_lead = 1'b0;
    s_trail = 1'b0;
    s_act = 1'b0;
    samp_ev = 1'b0;
    out_ev = 1'b0;
    new_byte = {st_reg.shift_register[6:0], st_reg.sdi_sync};
    st_next = st_reg;
    st_next.flag = 1'b0;
    st_next.wake = 1'b0;

    // Two-flop synchronisers; edge detect uses only the second stage
    st_next.sck_meta = sck_in;
    st_next.sck_sync = st_reg.sck_meta;
    st_next.sck_prev = st_reg.sck_sync;
    st_next.sdi_meta = sdi_in;
    st_next.sdi_sync = st_reg.sdi_meta;
    st_next.ss_meta = slave_select_n_in;
    st_next.ss_sync = st_reg.ss_meta;

    // Mode decode
    unique case (st_reg.port_mode_field)
      MODE_MASTER_DIV4, MODE_MASTER_DIV16,
      MODE_MASTER_DIV64, MODE_MASTER_TIMER: is_master = 1'b1; // [R14]
      MODE_SLAVE_SS: begin
        is_slave = 1'b1;
        ss_high = st_reg.ss_sync; // [R23]
      end
      MODE_SLAVE_FREE: is_slave = 1'b1; // [R14]
      default: ;
    endcase
    busy = (st_reg.xfer == XF_MASTER) || (st_reg.bit_cnt != 3'h0);

    // Write channel: address and data are held until both are present
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata[7:0];
      st_next.w_lane = s_axi_wstrb[0];
    end
    do_wr = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (do_wr) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (st_reg.aw_addr)
        OFS_STATUS: if (st_reg.w_lane) begin
          st_next.sample_point = st_reg.w_data[STAT_SAMPLE]; // [R4]
          st_next.clock_edge = st_reg.w_data[STAT_CKE]; // [R6]
        end
        OFS_CONTROL: if (st_reg.w_lane) begin
          st_next.write_collision = st_reg.w_data[CTRL_COLLIDE];
          st_next.receive_overflow = st_reg.w_data[CTRL_OV];
          st_next.port_enable = st_reg.w_data[CTRL_EN];
          st_next.clock_polarity = st_reg.w_data[CTRL_POLARITY];
          st_next.port_mode_field = st_reg.w_data[3:0];
        end
        OFS_BUFFER: if (st_reg.w_lane) begin
          if (busy) begin
            st_next.write_collision = 1'b1; // [R9]
          end else begin
            st_next.transfer_buffer = st_reg.w_data; // [R2]
            st_next.shift_register = st_reg.w_data; // [R2]
            st_next.sdo_bit = st_reg.w_data[7]; // [R19]
            if (st_reg.port_enable && is_master) begin
              st_next.xfer = XF_MASTER; // [R17]
              st_next.half_cnt = '0;
              st_next.bit_cnt = '0;
            end
          end
        end
        OFS_PINS: ;
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    st_next.awready = !st_next.aw_full;
    st_next.wready = !st_next.w_full;

    // Read channel: answer registered at the handshake edge
    rd_take = s_axi_arvalid && st_reg.arready;
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (rd_take) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_STATUS: st_next.rdata = {st_reg.sample_point, st_reg.clock_edge, 1'b0,
          st_reg.stop_bit, 3'h0, st_reg.buffer_full}; // [R8]
        OFS_CONTROL: st_next.rdata = {st_reg.write_collision, st_reg.receive_overflow,
          st_reg.port_enable, st_reg.clock_polarity, st_reg.port_mode_field};
        OFS_BUFFER: begin
          st_next.rdata = st_reg.transfer_buffer;
          buf_rd = 1'b1;
          st_next.buffer_full = 1'b0; // [R8]
        end
        OFS_PINS: st_next.rdata = {6'h00, busy, st_reg.sck_sync};
        default: begin
          st_next.rdata = 8'h00;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    st_next.arready = !st_next.rvalid;

    // Master event decode for the current half period
    lead = !st_reg.half_cnt[0] && (st_reg.half_cnt < HALF_LAST);
    trail = st_reg.half_cnt[0];
    endt = st_reg.half_cnt == HALF_LAST;
    m_mid = st_reg.clock_edge ? lead : trail; // [R6]
    m_out = st_reg.clock_edge ? trail : lead; // [R6]
    m_end = st_reg.clock_edge ? trail
      : ((lead && st_reg.half_cnt != 5'h00) || endt);
    m_samp = st_reg.sample_point ? m_end : m_mid; // [R4]

    // Slave edges from the synchronised pin clock
    s_edge = st_reg.sck_sync != st_reg.sck_prev;
    s_lead = s_edge && (st_reg.sck_prev == st_reg.clock_polarity);
    s_trail = s_edge && (st_reg.sck_prev != st_reg.clock_polarity);
    s_act = st_reg.port_enable && is_slave && !ss_high; // [R20] [R22]

    if (st_reg.xfer == XF_MASTER) begin
      samp_ev = tick && m_samp;
      out_ev = tick && m_out;
    end else if (s_act) begin
      samp_ev = st_reg.clock_edge ? s_lead : s_trail; // [R20]
      out_ev = st_reg.clock_edge ? s_trail : s_lead; // [R20]
    end

    // Master clock: toggles per half tick, rests at idle level otherwise
    if (st_reg.xfer == XF_MASTER) begin
      if (tick) begin
        st_next.half_cnt = st_reg.half_cnt + 5'h01;
        if (endt) begin
          st_next.xfer = XF_IDLE;
          st_next.half_cnt = '0;
        end else begin
          st_next.sck_level = !st_reg.sck_level;
        end
      end
    end else begin
      st_next.sck_level = st_reg.clock_polarity; // [R7]
    end

    // Output bit moves on its edge; next bit is sr[6] if sampling now
    if (out_ev) begin
      st_next.sdo_bit = samp_ev ? st_reg.shift_register[6]
        : st_reg.shift_register[7]; // [R3]
    end

    // Input capture, most significant bit first
    if (samp_ev) begin
      st_next.shift_register = new_byte; // [R3] [R18]
      st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
      if (st_reg.bit_cnt == LAST_BIT) begin
        st_next.bit_cnt = '0;
        st_next.flag = 1'b1; // [R1] [R20]
        if (is_slave && st_reg.buffer_full && !buf_rd) begin
          st_next.receive_overflow = 1'b1; // [R10]
        end else begin
          st_next.transfer_buffer = new_byte; // [R1] [R11]
          st_next.buffer_full = 1'b1; // [R1] [R8]
        end
        st_next.wake = is_slave; // [R22]
      end
    end

    // Slave select high or port disabled resets the bit counter
    if (ss_high) begin
      st_next.bit_cnt = '0; // [R23]
    end
    if (!st_reg.port_enable) begin
      st_next.bit_cnt = '0;
      st_next.xfer = XF_IDLE;
      st_next.stop_bit = 1'b0; // [R13]
    end

    // Pin ownership follows the mode being written, so enabling as slave never
    // drives the clock pin for a cycle; disabled port releases every pin
    st_next.pins_active = st_next.port_enable; // [R12]
    st_next.sck_oe = st_next.port_enable
      && (st_next.port_mode_field <= MODE_MASTER_TIMER); // [R12]
    st_next.sdo_oe = st_next.port_enable && (st_next.port_mode_field <= MODE_SLAVE_FREE)
      && !sdo_direction_input && !ss_high; // [R12] [R18] [R23]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output comes straight from the state register
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = {24'h000000, st_reg.rdata};
  assign s_axi_rresp = st_reg.rresp;
  assign sck_out = st_reg.sck_level;
  assign sck_oe = st_reg.sck_oe;
  assign sdo_out = st_reg.sdo_bit;
  assign sdo_oe = st_reg.sdo_oe;
  assign port_pins_active = st_reg.pins_active;
  assign port_interrupt_flag = st_reg.flag;
  assign wake_request = st_reg.wake;

endmodule : sync_serial_unit

// File: verif/spi_port_checker.sv
// Purpose: Port-level timing checks for the serial port.
// Assumes: One clk domain; sys_rst synchronous, active high.
// Notes: Register state is not visible here, so checks tie outputs to port events.
module spi_port_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sck_oe,
  input wire logic sdo_oe,
  input wire logic port_pins_active,
  input wire logic port_interrupt_flag,
  input wire logic wake_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Handshake steps of the two register transfers
  sequence w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence r_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  chk_write_answer:
    assert property (w_taken |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  chk_read_answer:
    assert property (r_taken |=> s_axi_rvalid) else $error("read answer late");
  chk_aw_busy:
    assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("awready stayed high");
  chk_bvalid_drop:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held");
  chk_rvalid_drop:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid held");
  chk_rdata_upper:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata upper set");
  chk_flag_pulse:
    assert property ($rose(port_interrupt_flag) |=> !port_interrupt_flag) else $error("flag long");
  chk_wake_pulse:
    assert property (wake_request |=> !wake_request) else $error("wake long");
  chk_wake_slave:
    assert property (wake_request |-> !sck_oe && port_pins_active) else $error("wake in master");
  chk_pins_off:
    assert property (!port_pins_active [*2] |-> !sck_oe && !sdo_oe) else $error("pins driven");
endmodule : spi_port_checker

bind sync_serial_unit spi_port_checker chk_u (.*);

// File: verif/spi_far_end.sv
// Purpose: Far-side SPI device: slave to a master port, master to a slave port.
// Assumes: Master role runs a 160 ns serial period with the clock idle low.
// Notes: Data line shows a changing pattern once released, so stale bits never pass.
module spi_far_end (
  input wire logic sck,
  input wire logic sdo,
  input wire logic sck_oe,
  output logic sdi,
  output logic sck_drv,
  output logic ss_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  logic idle_high = 1'h0;

  // Clock rests idle before any slave enable; select off between frames
  initial begin
    sck_drv = 1'h0;
    ss_n = 1'h1;
    sdi = 1'h0;
  end

  // Slave role: sample on leading edge, next bit on trailing edge
  always @(sck) begin
    if (sck_oe === 1'h1 && (sck ^ idle_high)) begin
      rx <= {rx[6:0], sdo};
    end else if (sck_oe === 1'h1) begin
      sdi <= tx[6];
      tx <= {tx[6:0], ~tx[7]};
    end
  end

  task automatic arm(input logic [7:0] b);
    tx = b;
    sdi = b[7];
  endtask : arm

  // Master role: output on rising edge, sample on falling edge
  task automatic xfer(input logic [7:0] mo, output logic [7:0] mi);
    #3; // Off the clk edge, so pin changes never race the synchronisers
    ss_n = 1'h0;
    #320;
    for (int i = 7; i >= 0; i--) begin
      sck_drv = 1'h1;
      sdi = mo[i];
      #80;
      sck_drv = 1'h0;
      mi[i] = sdo;
      #80;
    end
    #240;
    ss_n = 1'h1;
    sdi = ~sdi;
  endtask : xfer
endmodule : spi_far_end

// File: verif/spi_master_slave_port_tb.sv
// Purpose: Register-level tests of the serial port against a far-side model.
// Assumes: 100 MHz clk; timer pulse every fourth cycle.
// Notes: No receive check at the /4 rate, too fast for the pin synchronisers.
module spi_master_slave_port_tb
  import spi_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic sdo_direction_input = 1'h0, timer_two_output = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire sck_out, sck_oe, sdo_out, sdo_oe, port_pins_active, port_interrupt_flag;
  wire wake_request, far_sck, sdi_in, slave_select_n_in;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire sck_in = sck_oe ? sck_out : far_sck;
  int miscompares = 0, tests_run = 0, cycles = 0, wakes = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] mi;
  realtime t0;
  logic [5:0] hl [4] = '{HALF_DIV4, HALF_DIV16, HALF_DIV64, 6'h04};

  sync_serial_unit dut_u (.*);
  // A released data-out pin shows the inverse, so an undriven bit never passes
  spi_far_end far_u (.sck(sck_in), .sdo(sdo_oe ? sdo_out : ~sdo_out), .sck_oe(sck_oe), .sdi(sdi_in),
    .sck_drv(far_sck), .ss_n(slave_select_n_in));

  always #5 clk = ~clk;

  // Timer pulses, wake count and the hang limit
  always @(posedge clk) begin
    timer_two_output <= (cycles % 4 == 0);
    if (wake_request === 1'h1) wakes++;
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // Let registered outputs settle past the next edges
  task automatic step;
    repeat (4) @(posedge clk);
    #1;
  endtask : step

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic aw = 1'h1;
    logic w = 1'h1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (aw && s_axi_awready === 1'h1) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready === 1'h1) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar = 1'h1;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (ar && s_axi_arready === 1'h1) begin
        ar = 1'h0;
        s_axi_arvalid <= 1'h0;
      end
    end while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    rd(OFS_STATUS, d, r);
    check("status reset", d, 32'h0);
    rd(OFS_CONTROL, d, r);
    check("control reset", d, 32'h0);
    rd(4'h2, d, r);
    check("unmapped resp", r, RESP_SLVERR);
    // Master /16 with early data, then a write while busy
    wr(OFS_STATUS, 8'h40);
    wr(OFS_CONTROL, 8'h21);
    far_u.arm(8'h3c);
    wr(OFS_BUFFER, 8'ha5);
    #1;
    check("first bit", sdo_out, 32'h1);
    wr(OFS_BUFFER, 8'hff);
    rd(OFS_CONTROL, d, r);
    check("collision", d, 32'ha1);
    @(posedge clk iff port_interrupt_flag === 1'h1);
    check("far rx", far_u.rx, 32'ha5);
    rd(OFS_STATUS, d, r);
    check("full", d, 32'h41);
    rd(OFS_BUFFER, d, r);
    check("rx byte", d, 32'h3c);
    rd(OFS_STATUS, d, r);
    check("full cleared", d, 32'h40);
    rd(OFS_CONTROL, d, r);
    check("no overflow", d, 32'ha1);
    // Each master rate, one idle-high run and a receive-only run
    for (int m = 0; m < 4; m++) begin
      sdo_direction_input <= (m == 2);
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_STATUS, {1'(m == 3), 7'h40});
      wr(OFS_CONTROL, {3'h1, 1'(m == 1), 4'(m)});
      far_u.idle_high = (m == 1);
      step;
      check("idle clock", sck_out, 32'(m == 1));
      check("sdo enable", sdo_oe, 32'(m != 2));
      far_u.arm(8'hc3);
      wr(OFS_BUFFER, 8'h96);
      @(posedge sck_out) t0 = $realtime;
      @(posedge sck_out) check("period", $rtoi(($realtime - t0) / 10.0), 2 * hl[m]);
      @(posedge clk iff port_interrupt_flag === 1'h1);
      rd(OFS_BUFFER, d, r);
      if (m != 0) check("rate rx", d, 32'hc3);
      if (m != 2) check("rate tx", far_u.rx, 32'h96);
    end
    // Slave with select, clock idle low, output on leading edge
    sdo_direction_input <= 1'h0;
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_STATUS, 8'h00);
    wr(OFS_CONTROL, 8'h24);
    wr(OFS_BUFFER, 8'h96);
    far_u.xfer(8'h5a, mi);
    check("slave tx", mi, 32'h96);
    check("wake", wakes, 32'h1);
    step;
    check("select off", sdo_oe, 32'h0);
    far_u.xfer(8'h11, mi);
    rd(OFS_CONTROL, d, r);
    check("overflow", d, 32'h64);
    rd(OFS_BUFFER, d, r);
    check("kept byte", d, 32'h5a);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_CONTROL, 8'h25);
    step;
    check("free select", sdo_oe, 32'h1);
    wr(OFS_CONTROL, 8'h00);
    step;
    check("pins off", {port_pins_active, sck_oe, sdo_oe}, 32'h0);
    rd(OFS_STATUS, d, r);
    check("stop bit", d, 32'h0);
    give_verdict();
  end
endmodule : spi_master_slave_port_tb
